// ---- core/spdee_slave.sv ----
// Purpose: two-wire slave giving byte/page write and reads of a 256-byte store, with write protection of its lower half
// Assumes: SCL and SDA arrive asynchronously and are oversampled by i_mclk
// Notes: protection bits are mirrored to o_nv_* and reloaded from i_nv_*_init after reset
`timescale 1ns/1ps
module spdee_slave
  import spdee_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Two-wire link
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // Address pins
  input wire logic i_addr_pin_low,
  input wire logic i_addr_pin_mid,
  input wire logic i_addr_pin_high,
  input wire logic i_pin_overvoltage_level,
  // Non-volatile protection image
  input wire logic i_nv_perm_init,
  input wire logic i_nv_rev_init,
  output logic o_nv_perm,
  output logic o_nv_rev,
  // Status
  output logic o_write_busy
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] BUSY_LOAD = CW'(WRITE_CYCLES - 1);

  logic [7:0] s1_ff, s2_ff;
  logic scl_d_ff, sda_d_ff;
  logic scl, sda, ovl, rise, fall, start, stop;
  logic [2:0] pins;
  spdee_state_t state_ff;
  logic [2:0] bitcnt_ff;
  logic [7:0] shreg_ff;
  logic [1:0] bidx_ff;
  logic is_prot_ff, is_read_ff, ack_ff, ackph_ff, addr_ack_ff, sda_oe_ff;
  spdee_prot_t cmd_ff;
  logic [7:0] ptr_ff;
  logic [7:0] buf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_ff;
  logic pend_ff, pend_prot_ff, busy_ff, perm_ff, rev_ff;
  logic [CW-1:0] busy_cnt_ff;
  logic [1:0] ld_cnt_ff;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] byte_in;
  spdee_prot_t kind;
  logic mem_hit, prot_hit, prot_ok, lower_locked, commit;

  // Two-stage synchronisers for every pin
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_ff <= 8'hff;
      s2_ff <= 8'hff;
    end else begin
      s1_ff <= {i_nv_rev_init, i_nv_perm_init, i_pin_overvoltage_level, i_addr_pin_high,
                i_addr_pin_mid, i_addr_pin_low, i_sda, i_scl};
      s2_ff <= s1_ff;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= s2_ff[0];
      sda_d_ff <= s2_ff[1];
    end
  end

  assign scl = s2_ff[0];
  assign sda = s2_ff[1];
  assign pins = {s2_ff[4], s2_ff[3], s2_ff[2]};
  assign ovl = s2_ff[5];
  assign rise = scl & ~scl_d_ff;
  assign fall = ~scl & scl_d_ff;
  assign start = scl & scl_d_ff & sda_d_ff & ~sda;
  assign stop = scl & scl_d_ff & ~sda_d_ff & sda;
  assign byte_in = {shreg_ff[6:0], sda};
  assign lower_locked = perm_ff | rev_ff;
  assign commit = busy_ff && (busy_cnt_ff == '0);

  // Protection instruction kind from hardware bits, pins and overvoltage
  always_comb begin
    kind = CMD_NONE;
    if (ovl) begin
      if (!pins[2] && byte_in[3:1] == pins) begin
        kind = pins[1] ? CMD_CLR : CMD_REV;
      end
    end else if (byte_in[3:1] == pins) begin
      kind = CMD_PERM;
    end
  end

  assign mem_hit = !busy_ff && byte_in[7:4] == FIX_MEM && byte_in[3:1] == pins && !ovl;
  assign prot_hit = !busy_ff && byte_in[7:4] == FIX_PROT && !perm_ff && kind != CMD_NONE;
  assign prot_ok = !(rev_ff && kind == CMD_REV);

  // Bit-level protocol engine
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 3'h0;
      shreg_ff <= 8'h00;
      bidx_ff <= IDX_DEV;
      is_prot_ff <= 1'b0;
      is_read_ff <= 1'b0;
      cmd_ff <= CMD_NONE;
      ack_ff <= 1'b0;
      ackph_ff <= 1'b0;
      addr_ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ptr_ff <= 8'h00;
      mask_ff <= '0;
      pend_ff <= 1'b0;
      pend_prot_ff <= 1'b0;
    end else if (start) begin
      state_ff <= ST_RX;
      bitcnt_ff <= 3'h0;
      bidx_ff <= IDX_DEV;
      sda_oe_ff <= 1'b0;
      // A poll during the write cycle must not discard the page being written
      if (!busy_ff) begin
        pend_ff <= 1'b0;
        pend_prot_ff <= 1'b0;
        mask_ff <= '0;
      end
    end else if (stop) begin
      // Pending work survives the stop that launches its write cycle
      state_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (rise) begin
            shreg_ff <= byte_in;
            bitcnt_ff <= bitcnt_ff + 3'h1;
            if (bitcnt_ff == BIT_LAST) begin
              state_ff <= ST_ACK;
              ackph_ff <= 1'b0;
              addr_ack_ff <= (bidx_ff == IDX_DEV);
              if (bidx_ff == IDX_DEV) begin
                is_prot_ff <= prot_hit;
                is_read_ff <= byte_in[0];
                if (!busy_ff) begin
                  cmd_ff <= kind;
                end
                ack_ff <= mem_hit || (prot_hit && prot_ok);
                if (mem_hit && byte_in[0]) begin
                  shreg_ff <= mem[ptr_ff];
                  ptr_ff <= ptr_ff + 8'h01;
                end
              end else if (bidx_ff == IDX_WADDR) begin
                ack_ff <= 1'b1;
                if (!is_prot_ff) begin
                  ptr_ff <= byte_in;
                end
              end else if (is_prot_ff) begin
                ack_ff <= 1'b1;
                pend_prot_ff <= !(cmd_ff == CMD_CLR && !rev_ff);
              end else if (lower_locked && !ptr_ff[7]) begin
                ack_ff <= 1'b0;
                pend_ff <= 1'b0;
              end else begin
                ack_ff <= 1'b1;
                buf_ff[ptr_ff[3:0]] <= byte_in;
                mask_ff[ptr_ff[3:0]] <= 1'b1;
                ptr_ff[3:0] <= ptr_ff[3:0] + 4'h1;
                pend_ff <= 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (fall && !ackph_ff) begin
            sda_oe_ff <= ack_ff;
            ackph_ff <= 1'b1;
          end else if (fall) begin
            bitcnt_ff <= 3'h0;
            if (!ack_ff || (addr_ack_ff && is_prot_ff && is_read_ff)) begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else if (addr_ack_ff && is_read_ff) begin
              sda_oe_ff <= ~shreg_ff[7];
              state_ff <= ST_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff <= ST_RX;
              bidx_ff <= (bidx_ff == IDX_DEV) ? IDX_WADDR : IDX_DATA;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            sda_oe_ff <= ~shreg_ff[7];
          end else if (rise) begin
            shreg_ff <= {shreg_ff[6:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + 3'h1;
            if (bitcnt_ff == BIT_LAST) begin
              state_ff <= ST_MACK;
            end
          end
        end
        ST_MACK: begin
          if (fall) begin
            sda_oe_ff <= 1'b0;
          end else if (rise) begin
            if (!sda) begin
              shreg_ff <= mem[ptr_ff];
              ptr_ff <= ptr_ff + 8'h01;
              state_ff <= ST_TX;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Internal write cycle timer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= '0;
    end else if (busy_ff) begin
      busy_cnt_ff <= busy_cnt_ff - 1'b1;
      if (busy_cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end
    end else if (stop && (pend_ff || pend_prot_ff)) begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= BUSY_LOAD;
    end
  end

  // Protection state, reloaded from the non-volatile image after reset
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ld_cnt_ff <= 2'h0;
      perm_ff <= 1'b0;
      rev_ff <= 1'b0;
    end else if (ld_cnt_ff != LOAD_DONE) begin
      ld_cnt_ff <= ld_cnt_ff + 2'h1;
      if (ld_cnt_ff == LOAD_AT) begin
        perm_ff <= s2_ff[6];
        rev_ff <= s2_ff[7];
      end
    end else if (commit && pend_prot_ff) begin
      if (cmd_ff == CMD_PERM) begin
        perm_ff <= 1'b1;
      end else if (cmd_ff == CMD_REV) begin
        rev_ff <= 1'b1;
      end else if (cmd_ff == CMD_CLR) begin
        rev_ff <= 1'b0;
      end
    end
  end

  // Array update at the end of the write cycle
  always_ff @(posedge i_mclk) begin
    if (commit && pend_ff) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_ff[i]) begin
          mem[{ptr_ff[7:4], 4'(i)}] <= buf_ff[i];
        end
      end
    end
  end

  assign o_sda_oe = sda_oe_ff;
  assign o_nv_perm = perm_ff;
  assign o_nv_rev = rev_ff;
  assign o_write_busy = busy_ff;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_busy_addr_nack: assert property (state_ff == ST_ACK && addr_ack_ff && busy_ff |-> !ack_ff)
    else $error("address acknowledged during write cycle");
  a_stop_starts_write: assert property (stop && pend_ff && !busy_ff |=> busy_ff && busy_cnt_ff == BUSY_LOAD)
    else $error("write cycle not started on stop");
  a_busy_ends: assert property (busy_ff && busy_cnt_ff == '0 |=> !busy_ff)
    else $error("write cycle did not end");
  a_perm_sticky: assert property (ld_cnt_ff == LOAD_DONE && perm_ff |=> perm_ff)
    else $error("permanent protection cleared");
  a_perm_prot_nack: assert property (state_ff == ST_ACK && addr_ack_ff && is_prot_ff |-> !perm_ff)
    else $error("protection instruction taken while permanent");
  a_lower_data_nack: assert property (rise && state_ff == ST_RX && bitcnt_ff == BIT_LAST && bidx_ff == IDX_DATA
    && !is_prot_ff && lower_locked && !ptr_ff[7] |=> !ack_ff && !pend_ff)
    else $error("protected lower write acknowledged");
  a_page_wrap: assert property (rise && state_ff == ST_RX && bitcnt_ff == BIT_LAST && bidx_ff == IDX_DATA
    && !is_prot_ff |=> ptr_ff[7:4] == $past(ptr_ff[7:4]))
    else $error("page pointer left its page");
  a_tx_drive: assert property (state_ff == ST_TX && fall && !start && !stop |=> sda_oe_ff == !$past(shreg_ff[7]))
    else $error("transmit bit not driven");
  c_page_write: cover property (commit && pend_ff && mask_ff[1] && mask_ff[0]);
  c_seq_read: cover property (state_ff == ST_MACK && rise && !sda);
  c_prot_commit: cover property (commit && pend_prot_ff);
endmodule

// ---- inc/spdee_pkg.sv ----
// Purpose: constants and types for the serial SPD memory access block
// Assumes: 125 MHz core clock
// Notes: the write cycle time is a plain default, not a measured figure
package spdee_pkg;
  localparam logic [3:0] FIX_MEM = 4'ha;
  localparam logic [3:0] FIX_PROT = 4'h6;
  localparam int MEM_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_TIME_US = 5000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_WADDR = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] LOAD_AT = 2'h2;
  localparam logic [1:0] LOAD_DONE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_MACK = 3'h6
  } spdee_state_t;
  typedef enum logic [1:0] {
    CMD_PERM = 2'h0,
    CMD_REV = 2'h1,
    CMD_CLR = 2'h2,
    CMD_NONE = 2'h3
  } spdee_prot_t;
endpackage

// ---- sim/spdee_master.sv ----
// Purpose: two-wire bus master model facing the SPD memory block
// Assumes: bit time of 20 core clocks, a 160 ns SCL period
// Notes: SDA has a pull-up, so a released line reads high; SCL rests high between frames
`timescale 1ns/1ps
module spdee_master (
  // Clock
  input wire logic i_mclk,
  // Link
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  // Observation
  output logic o_seen,
  output logic [8:0] o_val
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_seen = 1'b0;
    o_val = 9'h000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= ~b;
    tick(5);
    o_scl <= 1'b1;
    tick(5);
    r = i_sda;
    tick(5);
    o_scl <= 1'b0;
    tick(5);
  endtask
  task automatic note(input logic [8:0] v);
    o_val <= v;
    o_seen <= 1'b1;
    tick(1);
    o_seen <= 1'b0;
  endtask
  // Also serves as repeated start when SCL is low
  task automatic start();
    o_sda_low <= 1'b0;
    tick(5);
    o_scl <= 1'b1;
    tick(5);
    o_sda_low <= 1'b1;
    tick(5);
    o_scl <= 1'b0;
    tick(5);
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    tick(5);
    o_scl <= 1'b1;
    tick(5);
    o_sda_low <= 1'b0;
    tick(10);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    note({b, r});
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    // Pull low to acknowledge; leave released after the last wanted byte
    bit_io(last, r);
    note({v, last});
  endtask
endmodule

// ---- sim/spdee_slave_test.sv ----
// Purpose: self-checking bench for the SPD memory slave
// Assumes: short write cycle parameter, stored protection image clear at power-up
// Notes: expected acks and read bytes are queued and matched by a monitor
`timescale 1ns/1ps
module spdee_slave_test
  import spdee_pkg::*;
;
  localparam int WCYC = 2000;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic nvp_init = 1'b0;
  logic nvr_init = 1'b0;
  logic pin_low, pin_mid, pin_high, ov, scl, sda_low, seen, sda_oe, nv_perm, nv_rev, busy;
  logic [2:0] pins;
  logic [8:0] val;
  logic [7:0] mem [256];
  logic [8:0] expq [$];
  int miscompares = 0;
  int checks_done = 0;
  wire logic sda;
  assign sda = ~(sda_low | sda_oe);
  always #4 i_mclk = ~i_mclk;
  spdee_slave #(.WRITE_CYCLES(WCYC)) spdee_slave_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_scl(scl),
    .i_sda(sda), .o_sda_oe(sda_oe), .i_addr_pin_low(pin_low), .i_addr_pin_mid(pin_mid),
    .i_addr_pin_high(pin_high), .i_pin_overvoltage_level(ov), .i_nv_perm_init(nvp_init),
    .i_nv_rev_init(nvr_init), .o_nv_perm(nv_perm), .o_nv_rev(nv_rev), .o_write_busy(busy));
  spdee_master spdee_master_i (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
    .o_seen(seen), .o_val(val));
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic complete_run();
    // Expected results that never appeared count as mismatches
    if (expq.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp_v);
    checks_done++;
    if (got !== exp_v) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp_v);
    end
  endtask
  // Power cycle: the stored image takes the current protection bits back in
  task automatic pcycle(input logic [8:0] exp_v);
    nvp_init <= nv_perm;
    nvr_init <= nv_rev;
    i_rstn <= 1'b0;
    tick(10);
    i_rstn <= 1'b1;
    tick(10);
    chk({7'h0, nv_perm, nv_rev}, exp_v);
  endtask
  always @(posedge i_mclk) begin
    if (seen === 1'b1) begin
      if (expq.size() == 0) chk(val, 9'h1ff);
      else chk(val, expq.pop_front());
    end
  end
  task automatic put(input logic [7:0] b, input logic nack);
    expq.push_back({b, nack});
    spdee_master_i.wbyte(b);
  endtask
  task automatic setp(input logic o, input logic [2:0] p);
    ov <= o;
    {pin_high, pin_mid, pin_low} <= p;
    tick(10);
  endtask
  task automatic ptx(input logic [7:0] dev, input logic nack);
    spdee_master_i.start();
    put(dev, nack);
    spdee_master_i.stop();
  endtask
  // Write frame; nk flags a missing ack on device, byte address and data
  task automatic wtx(input logic [7:0] dev, input logic [7:0] ba, input int n, input logic [2:0] nk,
                     input logic cyc);
    logic [7:0] d;
    logic b0;
    spdee_master_i.start();
    put(dev, nk[2]);
    put(ba, nk[1]);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, nk[0]);
      if (cyc && dev[7:4] == FIX_MEM) mem[{ba[7:4], ba[3:0] + i[3:0]}] = d;
    end
    b0 = busy;
    spdee_master_i.stop();
    tick(10);
    chk({7'h0, b0, busy}, {8'h0, cyc});
    if (cyc) ptx({FIX_MEM, pins, 1'b0}, 1'b1);
    for (int i = 0; busy === 1'b1; i++) begin
      if (i == 3000) begin
        miscompares++;
        complete_run();
      end
      @(posedge i_mclk);
    end
  endtask
  task automatic rtx(input logic [7:0] ba, input int n, input logic cur);
    spdee_master_i.start();
    if (!cur) begin
      put({FIX_MEM, pins, 1'b0}, 1'b0);
      put(ba, 1'b0);
      spdee_master_i.start();
    end
    put({FIX_MEM, pins, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      expq.push_back({mem[ba + i[7:0]], i == n - 1});
      spdee_master_i.rbyte(i == n - 1);
    end
    spdee_master_i.stop();
  endtask
  initial begin
    void'($urandom(32'hbf1831d6));
    pins = 3'($urandom);
    ov = 1'b0;
    {pin_high, pin_mid, pin_low} = pins;
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    tick(10);
    wtx({FIX_MEM, pins, 1'b0}, 8'hff, 1, 3'b000, 1'b1);
    wtx({FIX_MEM, pins, 1'b0}, 8'h00, 1, 3'b000, 1'b1);
    rtx(8'hff, 2, 1'b0);
    wtx({FIX_MEM, pins, 1'b0}, 8'h9c, 18, 3'b000, 1'b1);
    rtx(8'h90, 15, 1'b0);
    rtx(8'h9f, 1, 1'b1);
    wtx({FIX_MEM, ~pins, 1'b0}, 8'h40, 1, 3'b111, 1'b0);
    setp(1'b1, 3'b011);
    ptx(8'h67, 1'b0);
    wtx(8'h66, 8'($urandom), 1, 3'b000, 1'b0);
    setp(1'b1, 3'b001);
    wtx(8'h62, 8'($urandom), 1, 3'b000, 1'b1);
    chk({7'h0, nv_perm, nv_rev}, 9'h001);
    pcycle(9'h001);
    wtx(8'h62, 8'h00, 1, 3'b111, 1'b0);
    ptx(8'h63, 1'b1);
    setp(1'b0, pins);
    wtx({FIX_MEM, pins, 1'b0}, 8'h10, 1, 3'b001, 1'b0);
    ptx({FIX_PROT, pins, 1'b1}, 1'b0);
    setp(1'b1, 3'b011);
    wtx(8'h66, 8'h00, 1, 3'b000, 1'b1);
    setp(1'b0, pins);
    wtx({FIX_PROT, pins, 1'b0}, 8'h00, 1, 3'b000, 1'b1);
    chk({7'h0, nv_perm, nv_rev}, 9'h002);
    pcycle(9'h002);
    ptx({FIX_PROT, pins, 1'b1}, 1'b1);
    setp(1'b1, 3'b001);
    wtx(8'h62, 8'h00, 1, 3'b111, 1'b0);
    setp(1'b0, pins);
    wtx({FIX_MEM, pins, 1'b0}, 8'h20, 2, 3'b001, 1'b0);
    complete_run();
  end
endmodule
